// File: rtl/pfe_pkg.sv
// Shared constants, encodings and carriers of the port function block
package pfe_pkg;

	// ************************************************************
	// Sizes and register map
	// ************************************************************
	localparam int             NUM_PORTS   = 8;
	localparam int             ADDR_W      = 8;
	localparam int             DATA_W      = 32;
	localparam logic [7:0]     REG_CFG     = 8'h00;
	localparam logic [7:0]     REG_GPOUT   = 8'h04;
	localparam logic [7:0]     REG_ONESHOT = 8'h08;
	localparam logic [7:0]     REG_STATUS  = 8'h0c;
	localparam logic [31:0]    CFG_RESET   = 32'h0000_0000;
	localparam logic [31:0]    CFG_WMASK   = 32'h07ff_ffff;
	localparam logic [7:0]     GPOUT_RESET = 8'h00;
	localparam int             OS_TRIG_LSB = 0;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int             FILT_MIN_CYCLES = 3;
	localparam int             CLK_FREQ_HZ     = 100_000_000;
	localparam int             ONESHOT_TIME_MS = 26;
	localparam int             ONESHOT_CYCLES  =
		ONESHOT_TIME_MS * (CLK_FREQ_HZ / 1000);

	// ************************************************************
	// Encodings
	// ************************************************************
	typedef enum logic [1:0]
	{
		FSEL_INPUT  = 2'h0,
		FSEL_OUTPUT = 2'h1,
		FSEL_ALT_A  = 2'h2,
		FSEL_ALT_B  = 2'h3
	} pfe_fsel_e;

	typedef enum logic [1:0]
	{
		CM_X1     = 2'h0,
		CM_X2     = 2'h1,
		CM_X4     = 2'h2,
		CM_UPDOWN = 2'h3
	} pfe_cmode_e;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed
	{
		logic [4:0] reserved;
		logic       pulser_direction_invert;
		logic [1:0] pulser_count_mode;
		logic       index_edge_select;
		logic       encoder_direction_invert;
		logic [1:0] encoder_count_mode;
		logic       pulser_noise_filter_on;
		logic       encoder_noise_filter_on;
		logic       port1_output_polarity;
		logic       port0_output_polarity;
		logic [1:0] port7_function_select;
		logic [1:0] port6_function_select;
		logic [1:0] port5_function_select;
		logic [1:0] port4_function_select;
		logic [1:0] port3_function_select;
		logic [1:0] port2_function_select;
		logic [1:0] port1_function_select;
		logic [1:0] port0_function_select;
	} pfe_cfg_s;

	typedef struct packed
	{
		logic a;
		logic b;
	} pfe_phase_s;

	typedef struct packed
	{
		logic up;
		logic down;
	} pfe_cnt_s;

	typedef struct packed
	{
		logic [16:0] reserved;
		logic [1:0]  oneshot_busy;
		logic        index_level;
		pfe_phase_s  pulser_phase;
		pfe_phase_s  encoder_phase;
		logic [7:0]  port_level;
	} pfe_status_s;

endpackage

// File: rtl/pfe_filter.sv
// Noise filter for a group of phase inputs
`timescale 1ns/1ns
`default_nettype none
module pfe_filter
	import pfe_pkg::*;
#(
	parameter int W   = 2,
	parameter int CNT = FILT_MIN_CYCLES
)
(
	input  wire logic         clk,  // Reference clock
	input  wire logic         rst,  // Synchronous reset
	input  wire logic         ce,   // Clock enable
	input  wire logic         en,   // Filter on
	input  wire logic [W-1:0] din,  // Raw inputs
	output logic      [W-1:0] dout  // Conditioned inputs
);

	localparam int CW = $clog2(CNT);

	if (CNT < 2 || W < 1)
	begin : g_bad
		$error("pfe_filter: CNT must be at least 2");
	end

	logic [CW-1:0] cnt [W];

	// A change is taken only once it has held for CNT samples
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < W; i++)
		begin
			if (rst)
			begin
				dout[i] <= 1'b0;
				cnt[i]  <= '0;
			end
			else if (ce)
			begin
				if (!en || din[i] == dout[i])
				begin
					if (!en)
						dout[i] <= din[i];
					cnt[i] <= '0;
				end
				else if (cnt[i] == CW'(CNT - 1))
				begin
					dout[i] <= din[i];
					cnt[i]  <= '0;
				end
				else
					cnt[i] <= cnt[i] + 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// File: rtl/pfe_decoder.sv
// Quadrature or up/down decoder of one phase pair
`timescale 1ns/1ns
`default_nettype none
module pfe_decoder
	import pfe_pkg::*;
(
	input  wire logic       clk,    // Reference clock
	input  wire logic       rst,    // Synchronous reset
	input  wire logic       ce,     // Clock enable
	input  wire pfe_phase_s ph,     // Conditioned phases
	input  wire logic [1:0] mode,   // Count mode
	input  wire logic       invert, // Reverse direction
	output pfe_cnt_s        cnt     // Count pulses
);

	pfe_phase_s prev;
	logic       ar;
	logic       af;
	logic       br;
	logic       bf;
	logic       up;
	logic       dn;

	assign ar = ph.a & ~prev.a;
	assign af = ~ph.a & prev.a;
	assign br = ph.b & ~prev.b;
	assign bf = ~ph.b & prev.b;

	// In modes x1/x2/x4 up means phase a leads phase b; in up/down mode up is a rise of a
	always_comb
	begin
		up = 1'b0;
		dn = 1'b0;
		case (mode)
			CM_X1:
			begin
				up = ar & ~ph.b;
				dn = af & ~ph.b;
			end
			CM_X2:
			begin
				up = (ar & ~ph.b) | (af & ph.b);
				dn = (ar & ph.b) | (af & ~ph.b);
			end
			CM_X4:
			begin
				up = (ar & ~ph.b) | (af & ph.b)
					| (br & ph.a) | (bf & ~ph.a);
				dn = (ar & ph.b) | (af & ~ph.b)
					| (br & ~ph.a) | (bf & ph.a);
			end
			CM_UPDOWN:
			begin
				up = ar;
				dn = bf;
			end
			default:
			begin
				up = 1'b0;
				dn = 1'b0;
			end
		endcase
	end

	// Coincident up and down cancel: the net move is zero
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prev <= '0;
			cnt  <= '0;
		end
		else if (ce)
		begin
			prev     <= ph;
			cnt.up   <= (invert ? dn : up) & ~(up & dn);
			cnt.down <= (invert ? up : dn) & ~(up & dn);
		end
	end

endmodule
`default_nettype wire

// File: rtl/pfe_top.sv
// Port terminal functions and encoder/pulser input conditioning
//
// Functional notes
// - Terminal 4: input, output, match 2 active low, match 2 active high.
// - Terminal 5: input, output, match 3 active low, match 3 active high.
// - Terminal 6: input, output, match 4 active low, match 4 active high.
// - Terminal 7: input, output, match 5 active low, match 5 active high.
// - Terminal 0 accel flag or one-shot: polarity bit 0 low, 1 high.
// - Terminal 1 decel flag or one-shot: polarity bit 0 low, 1 high.
// - Encoder filter bit set filters both encoder phases before decoding.
// - Pulser filter bit set filters both pulser phases before decoding.
// - Encoder modes 00/01/10: quadrature x1/x2/x4, up when a leads.
// - Encoder mode 11: up on phase a rise, down on phase b fall.
// - Encoder invert bit reverses every encoder count direction.
// - Index acts on falling edge when select is 0, rising when 1.
// - Pulser modes 00/01/10: quadrature x1/x2/x4, up when a leads.
// - Pulser mode 11: up on pulser a rise, down on pulser b fall.
// - Pulser invert bit reverses every pulser count direction.
// - Filtered inputs ignore pulses shorter than three clock cycles.
// - One-shot mode on terminal 0 or 1 gives a 26 ms pulse.
`timescale 1ns/1ns
`default_nettype none
module pfe_top
	import pfe_pkg::*;
#(
	parameter int ONESHOT_LEN = ONESHOT_CYCLES,
	parameter int FILT_LEN    = FILT_MIN_CYCLES
)
(
	input  wire logic [ADDR_W-1:0]    addr,              // Register address
	input  wire logic [DATA_W-1:0]    wdata,             // Write data
	input  wire logic                 wr_en,             // Write strobe
	input  wire logic                 rd_en,             // Read strobe
	output logic      [DATA_W-1:0]    rdata,             // Read data
	input  wire logic                 ref_clk,           // Reference clock
	input  wire logic                 rst,               // Sync reset
	input  wire logic                 ce,                // Clock enable
	input  wire logic [NUM_PORTS-1:0] port_in,           // Terminal levels
	output logic      [NUM_PORTS-1:0] port_out,          // Terminal drive
	output logic      [NUM_PORTS-1:0] port_oe,           // Terminal enable
	input  wire logic                 accel_flag_out,    // Accelerating
	input  wire logic                 decel_flag_out,    // Decelerating
	input  wire logic                 low_speed_flag_out,// Low speed feed
	input  wire logic                 match1_out,        // Comparator 1
	input  wire logic                 match2_out,        // Comparator 2
	input  wire logic                 match3_out,        // Comparator 3
	input  wire logic                 match4_out,        // Comparator 4
	input  wire logic                 match5_out,        // Comparator 5
	input  wire pfe_phase_s           encoder_phase,     // Encoder a/b
	input  wire pfe_phase_s           pulser_phase,      // Pulser a/b
	input  wire logic                 encoder_index,     // Encoder index
	output pfe_cnt_s                  encoder_count,     // Encoder pulses
	output pfe_cnt_s                  pulser_count,      // Pulser pulses
	output logic                      index_event        // Index edge seen
);

	localparam int OS_W = $clog2(ONESHOT_LEN + 1);

	// ************************************************************
	// Parameter checks
	// ************************************************************
	if (ONESHOT_LEN < 1)
	begin : g_bad_os
		$error("pfe_top: ONESHOT_LEN must be at least 1");
	end

	if (FILT_LEN < 2)
	begin : g_bad_filt
		$error("pfe_top: FILT_LEN must be at least 2");
	end

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic pfe_pol(input logic sig, input logic act_hi);
		return act_hi ? sig : ~sig;
	endfunction

	function automatic logic pfe_hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] reg_addr);
		return a == reg_addr;
	endfunction

	// ************************************************************
	// Registers
	// ************************************************************
	pfe_cfg_s             cfg;
	logic [NUM_PORTS-1:0] gp_out;
	logic [OS_W-1:0]      os_cnt [2];
	logic [1:0]           os_busy;
	logic [1:0]           os_trig;
	pfe_phase_s           enc_cond;
	pfe_phase_s           pls_cond;
	logic                 index_prev;
	pfe_status_s          status;
	logic [DATA_W-1:0]    next_rdata;

	// Upper bits are held at zero whatever software writes
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			cfg <= pfe_cfg_s'(CFG_RESET);
		else if (ce && wr_en && pfe_hit(addr, REG_CFG))
			cfg <= pfe_cfg_s'(wdata & CFG_WMASK);
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			gp_out <= GPOUT_RESET;
		else if (ce && wr_en && pfe_hit(addr, REG_GPOUT))
			gp_out <= wdata[NUM_PORTS-1:0];
	end

	// ************************************************************
	// One-shot timers of terminals 0 and 1
	// ************************************************************
	assign os_trig = (wr_en && pfe_hit(addr, REG_ONESHOT))
		? wdata[OS_TRIG_LSB +: 2] : 2'h0;

	// A trigger while running restarts the full length
	always_ff @(posedge ref_clk)
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (rst)
				os_cnt[i] <= '0;
			else if (ce)
			begin
				if (os_trig[i])
					os_cnt[i] <= OS_W'(ONESHOT_LEN);
				else if (os_cnt[i] != '0)
					os_cnt[i] <= os_cnt[i] - 1'b1;
			end
		end
	end

	assign os_busy[0] = os_cnt[0] != '0;
	assign os_busy[1] = os_cnt[1] != '0;

	// ************************************************************
	// Terminal function multiplexer
	// ************************************************************
	logic [1:0]           fsel   [NUM_PORTS];
	logic                 sig_a  [NUM_PORTS];
	logic                 sig_b  [NUM_PORTS];
	logic                 hi_a   [NUM_PORTS];
	logic                 hi_b   [NUM_PORTS];
	logic [NUM_PORTS-1:0] next_port_out;
	logic [NUM_PORTS-1:0] next_port_oe;

	assign fsel[0] = cfg.port0_function_select;
	assign fsel[1] = cfg.port1_function_select;
	assign fsel[2] = cfg.port2_function_select;
	assign fsel[3] = cfg.port3_function_select;
	assign fsel[4] = cfg.port4_function_select;
	assign fsel[5] = cfg.port5_function_select;
	assign fsel[6] = cfg.port6_function_select;
	assign fsel[7] = cfg.port7_function_select;

	// Terminals 0 and 1 each use their own polarity bit for both of their special modes
	assign sig_a[0] = accel_flag_out;
	assign sig_b[0] = os_busy[0];
	assign hi_a[0]  = cfg.port0_output_polarity;
	assign hi_b[0]  = cfg.port0_output_polarity;
	assign sig_a[1] = decel_flag_out;
	assign sig_b[1] = os_busy[1];
	assign hi_a[1]  = cfg.port1_output_polarity;
	assign hi_b[1]  = cfg.port1_output_polarity;

	// Terminals 2 to 7: one source, low-true then high-true
	assign sig_a[2] = low_speed_flag_out;
	assign sig_a[3] = match1_out;
	assign sig_a[4] = match2_out;
	assign sig_a[5] = match3_out;
	assign sig_a[6] = match4_out;
	assign sig_a[7] = match5_out;

	for (genvar g = 2; g < NUM_PORTS; g++)
	begin : g_match
		assign sig_b[g] = sig_a[g];
		assign hi_a[g]  = 1'b0;
		assign hi_b[g]  = 1'b1;
	end

	always_comb
	begin
		next_port_out = '0;
		next_port_oe  = '0;
		for (int i = 0; i < NUM_PORTS; i++)
		begin
			case (fsel[i])
				FSEL_INPUT:
				begin
					next_port_out[i] = 1'b0;
					next_port_oe[i]  = 1'b0;
				end
				FSEL_OUTPUT:
				begin
					next_port_out[i] = gp_out[i];
					next_port_oe[i]  = 1'b1;
				end
				FSEL_ALT_A:
				begin
					next_port_out[i] = pfe_pol(sig_a[i], hi_a[i]);
					next_port_oe[i]  = 1'b1;
				end
				FSEL_ALT_B:
				begin
					next_port_out[i] = pfe_pol(sig_b[i], hi_b[i]);
					next_port_oe[i]  = 1'b1;
				end
				default:
				begin
					next_port_out[i] = 1'b0;
					next_port_oe[i]  = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			port_out <= '0;
			port_oe  <= '0;
		end
		else if (ce)
		begin
			port_out <= next_port_out;
			port_oe  <= next_port_oe;
		end
	end

	// ************************************************************
	// Encoder and pulser conditioning
	// ************************************************************
	pfe_filter #(
		.W   (2),
		.CNT (FILT_LEN)
	) u_enc_filter (
		.clk  (ref_clk),
		.rst  (rst),
		.ce   (ce),
		.en   (cfg.encoder_noise_filter_on),
		.din  (encoder_phase),
		.dout (enc_cond)
	);

	pfe_filter #(
		.W   (2),
		.CNT (FILT_LEN)
	) u_pls_filter (
		.clk  (ref_clk),
		.rst  (rst),
		.ce   (ce),
		.en   (cfg.pulser_noise_filter_on),
		.din  (pulser_phase),
		.dout (pls_cond)
	);

	pfe_decoder u_enc_decoder (
		.clk    (ref_clk),
		.rst    (rst),
		.ce     (ce),
		.ph     (enc_cond),
		.mode   (cfg.encoder_count_mode),
		.invert (cfg.encoder_direction_invert),
		.cnt    (encoder_count)
	);

	pfe_decoder u_pls_decoder (
		.clk    (ref_clk),
		.rst    (rst),
		.ce     (ce),
		.ph     (pls_cond),
		.mode   (cfg.pulser_count_mode),
		.invert (cfg.pulser_direction_invert),
		.cnt    (pulser_count)
	);

	// ************************************************************
	// Index edge
	// ************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			index_prev  <= 1'b0;
			index_event <= 1'b0;
		end
		else if (ce)
		begin
			index_prev  <= encoder_index;
			index_event <= cfg.index_edge_select
				? (encoder_index & ~index_prev)
				: (~encoder_index & index_prev);
		end
	end

	// ************************************************************
	// Read port
	// ************************************************************
	always_comb
	begin
		status               = '0;
		status.port_level    = port_in;
		status.encoder_phase = enc_cond;
		status.pulser_phase  = pls_cond;
		status.index_level   = encoder_index;
		status.oneshot_busy  = os_busy;
	end

	// Unmapped addresses read as zero
	always_comb
	begin
		next_rdata = '0;
		case (addr)
			REG_CFG:     next_rdata = DATA_W'(cfg);
			REG_GPOUT:   next_rdata = DATA_W'(gp_out);
			REG_ONESHOT: next_rdata = DATA_W'(os_busy);
			REG_STATUS:  next_rdata = DATA_W'(status);
			default:     next_rdata = '0;
		endcase
	end

	// Data stand for the one cycle after the strobe only
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			rdata <= '0;
		else if (ce)
			rdata <= rd_en ? next_rdata : '0;
	end

endmodule
`default_nettype wire

// File: dv/pfe_properties.sv
// Concurrent checks on the terminal drive, encoder decoder and index edge of pfe_top
`timescale 1ns/1ns
`default_nettype none
module pfe_properties
	import pfe_pkg::*;
(
	input  wire logic [ADDR_W-1:0]    addr,           // Register address
	input  wire logic [DATA_W-1:0]    wdata,          // Write data
	input  wire logic                 wr_en,          // Write strobe
	input  wire logic                 ref_clk,        // Reference clock
	input  wire logic                 rst,            // Sync reset
	input  wire logic                 ce,             // Clock enable
	input  wire logic [NUM_PORTS-1:0] port_out,       // Terminal drive
	input  wire logic [NUM_PORTS-1:0] port_oe,        // Terminal enable
	input  wire logic                 accel_flag_out, // Accelerating
	input  wire logic                 decel_flag_out, // Decelerating
	input  wire logic                 match2_out,     // Comparator 2
	input  wire logic                 match3_out,     // Comparator 3
	input  wire pfe_phase_s           encoder_phase,  // Encoder a/b
	input  wire logic                 encoder_index,  // Encoder index
	input  wire pfe_cnt_s             encoder_count,  // Encoder pulses
	input  wire logic                 index_event     // Index edge seen
);
	// ************************************************************
	// Shadow of the written settings
	// ************************************************************
	pfe_cfg_s   cfg_q;
	logic [7:0] gp_q;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			cfg_q <= '0;
		else if (ce && wr_en && addr == REG_CFG)
			cfg_q <= wdata & CFG_WMASK;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			gp_q <= '0;
		else if (ce && wr_en && addr == REG_GPOUT)
			gp_q <= wdata[7:0];
	end

	// ************************************************************
	// Properties
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Lone a rise with b low, unfiltered x4, two enabled edges to surface
	sequence s_x4_rise;
		ce && cfg_q.encoder_count_mode == CM_X4
		&& !cfg_q.encoder_noise_filter_on
		&& !cfg_q.encoder_direction_invert
		&& $rose(encoder_phase.a) && $stable(encoder_phase.b)
		&& !encoder_phase.b ##1 ce;
	endsequence
	sequence s_idx_change;
		ce && $changed(encoder_index) ##1 ce;
	endsequence

	property p_t4;
		ce && cfg_q.port4_function_select == FSEL_ALT_A |=>
			port_oe[4] && port_out[4] == !$past(match2_out);
	endproperty
	property p_t5;
		ce && cfg_q.port5_function_select == FSEL_ALT_B |=>
			port_oe[5] && port_out[5] == $past(match3_out);
	endproperty
	property p_t6;
		ce && cfg_q.port6_function_select == FSEL_INPUT |=> !port_oe[6];
	endproperty
	property p_t7;
		ce && cfg_q.port7_function_select == FSEL_OUTPUT |=>
			port_oe[7] && port_out[7] == $past(gp_q[7]);
	endproperty
	property p_p0;
		ce && cfg_q.port0_function_select == FSEL_ALT_A |=> port_out[0] ==
			($past(accel_flag_out) ~^ $past(cfg_q.port0_output_polarity));
	endproperty
	property p_p1;
		ce && cfg_q.port1_function_select == FSEL_ALT_A |=> port_out[1] ==
			($past(decel_flag_out) ~^ $past(cfg_q.port1_output_polarity));
	endproperty
	property p_x4;
		s_x4_rise |=> encoder_count.up && !encoder_count.down;
	endproperty
	property p_idx;
		s_idx_change |-> index_event ==
			($past(encoder_index) == $past(cfg_q.index_edge_select));
	endproperty

	a_t4: assert property (p_t4) else $error("terminal 4 match drive");
	a_t5: assert property (p_t5) else $error("terminal 5 match drive");
	a_t6: assert property (p_t6) else $error("terminal 6 not input");
	a_t7: assert property (p_t7) else $error("terminal 7 gp drive");
	a_p0: assert property (p_p0) else $error("terminal 0 polarity");
	a_p1: assert property (p_p1) else $error("terminal 1 polarity");
	a_x4: assert property (p_x4) else $error("x4 up pulse missing");
	a_idx: assert property (p_idx) else $error("index edge wrong");
endmodule

bind pfe_top pfe_properties u_props (.addr(addr), .wdata(wdata),
	.wr_en(wr_en), .ref_clk(ref_clk), .rst(rst), .ce(ce),
	.port_out(port_out), .port_oe(port_oe),
	.accel_flag_out(accel_flag_out), .decel_flag_out(decel_flag_out),
	.match2_out(match2_out), .match3_out(match3_out),
	.encoder_phase(encoder_phase), .encoder_index(encoder_index),
	.encoder_count(encoder_count), .index_event(index_event));
`default_nettype wire

// File: dv/pfe_partner.sv
// Encoder, manual pulser and port circuitry driving the block's inputs
`timescale 1ns/1ns
`default_nettype none
module pfe_partner
	import pfe_pkg::*;
(
	input  wire logic                 ref_clk,       // Reference clock
	output pfe_phase_s                encoder_phase, // Encoder a/b
	output pfe_phase_s                pulser_phase,  // Pulser a/b
	output logic                      encoder_index, // Encoder index
	output logic      [NUM_PORTS-1:0] port_in        // Terminal levels
);
	// Gray order a then b: stepping forward makes phase a lead
	localparam logic [1:0] GRAY [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
	logic [1:0] pos [2];

	initial
	begin
		encoder_phase = '0;
		pulser_phase = '0;
		encoder_index = 1'b0;
		port_in = 8'h5a;
		pos[0] = 2'h0;
		pos[1] = 2'h0;
	end

	task automatic put(input int ch, input logic [1:0] ab);
		@(posedge ref_clk);
		if (ch == 0)
			encoder_phase <= ab;
		else
			pulser_phase <= ab;
	endtask

	// Each state held four cycles so no two edges meet in the decoder
	task automatic step(input int ch, input bit fwd);
		pos[ch] = fwd ? pos[ch] + 2'h1 : pos[ch] - 2'h1;
		put(ch, GRAY[pos[ch]]);
		repeat (3) @(posedge ref_clk);
	endtask

	// Phase a pulse of w cycles from rest, the noise a scenario asks for
	task automatic glitch(input int ch, input int w);
		put(ch, 2'h2);
		repeat (w - 1) @(posedge ref_clk);
		put(ch, 2'h0);
		repeat (6) @(posedge ref_clk);
	endtask

	task automatic idx(input logic lvl);
		@(posedge ref_clk);
		encoder_index <= lvl;
		repeat (4) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking testbench of pfe_top
`timescale 1ns/1ns
`default_nettype none
module tb;
	import pfe_pkg::*;
	localparam int OS_LEN = 20;
	logic ref_clk = 0, rst = 1, ce = 1, wr_en = 0, rd_en = 0, src = 0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata, d;
	logic [NUM_PORTS-1:0] port_in, port_out, port_oe;
	pfe_phase_s encoder_phase, pulser_phase;
	pfe_cnt_s encoder_count, pulser_count;
	logic encoder_index, index_event;
	pfe_cfg_s c;
	int err_count = 0, n_compared = 0, b0, b1, up, dn, n;
	int cnt [5] = '{0, 0, 0, 0, 0};

	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cnt[0] += int'(encoder_count.up === 1'b1);
		cnt[1] += int'(encoder_count.down === 1'b1);
		cnt[2] += int'(pulser_count.up === 1'b1);
		cnt[3] += int'(pulser_count.down === 1'b1);
		cnt[4] += int'(index_event === 1'b1);
	end

	pfe_top #(.ONESHOT_LEN(OS_LEN), .FILT_LEN(FILT_MIN_CYCLES)) dut (
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .ref_clk(ref_clk), .rst(rst), .ce(ce),
		.port_in(port_in), .port_out(port_out), .port_oe(port_oe),
		.accel_flag_out(src), .decel_flag_out(src),
		.low_speed_flag_out(src), .match1_out(src), .match2_out(src),
		.match3_out(src), .match4_out(src), .match5_out(src),
		.encoder_phase(encoder_phase), .pulser_phase(pulser_phase),
		.encoder_index(encoder_index), .encoder_count(encoder_count),
		.pulser_count(pulser_count), .index_event(index_event));
	pfe_partner prt (.ref_clk(ref_clk), .encoder_phase(encoder_phase),
		.pulser_phase(pulser_phase), .encoder_index(encoder_index),
		.port_in(port_in));

	// ************************************************************
	// Bus cycles and comparison
	// ************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_regs();
		rd(REG_CFG, d);
		chk(d, 32'h0);
		wr(REG_CFG, 32'h07ff_ffff);
		rd(REG_CFG, d);
		chk(d, 32'h07ff_ffff);
		rd(8'h10, d);
		chk(d, 32'h0);
		rd(REG_STATUS, d);
		chk(d, 32'h0000_005a);
		wr(REG_GPOUT, 32'h0000_00a5);
		ce <= 1'b0;
		wr(REG_GPOUT, 32'h0000_0000);
		ce <= 1'b1;
		rd(REG_GPOUT, d);
		chk(d, 32'h0000_00a5);
	endtask
	task automatic t_ports();
		for (int m = 0; m < 4; m++)
			for (int v = 0; v < 2; v++)
			begin
				c = '0;
				c.port2_function_select = 2'(m);
				c.port3_function_select = 2'(m);
				c.port4_function_select = 2'(m);
				c.port5_function_select = 2'(m);
				c.port6_function_select = 2'(m);
				c.port7_function_select = 2'(m);
				c.port0_function_select = FSEL_ALT_A;
				c.port1_function_select = FSEL_ALT_A;
				c.port0_output_polarity = m[0];
				c.port1_output_polarity = !m[0];
				wr(REG_CFG, c);
				src <= v[0];
				repeat (2) @(posedge ref_clk);
				#1 chk(port_oe, {m == 0 ? 6'h00 : 6'h3f, 2'h3});
				if (m != 0)
					chk(port_out[7:2], m == 1 ? 6'h29 : {6{v[0] ^ !m[0]}});
				chk(port_out[1:0], {v[0] ^ m[0], !(v[0] ^ m[0])});
			end
	endtask
	task automatic t_oneshot();
		for (int p = 0; p < 2; p++)
		begin
			c = '0;
			c.port0_function_select = FSEL_ALT_B;
			c.port1_function_select = FSEL_ALT_B;
			c.port0_output_polarity = p[0];
			c.port1_output_polarity = p[0];
			wr(REG_CFG, c);
			wr(REG_ONESHOT, 32'h3);
			n = 0;
			b0 = 0;
			repeat (OS_LEN + 10)
			begin
				#1 n += int'(port_out[0] === p[0]);
				b0 += int'(port_out[1] === p[0]);
				@(posedge ref_clk);
			end
			chk(n, OS_LEN);
			chk(b0, OS_LEN);
		end
	endtask
	task automatic t_decode();
		for (int ch = 0; ch < 2; ch++)
			for (int m = 0; m < 4; m++)
				for (int inv = 0; inv < 2; inv++)
				begin
					c = '0;
					c.encoder_count_mode = ch == 0 ? 2'(m) : 2'h0;
					c.encoder_direction_invert = ch == 0 && inv == 1;
					c.pulser_count_mode = ch == 1 ? 2'(m) : 2'h0;
					c.pulser_direction_invert = ch == 1 && inv == 1;
					wr(REG_CFG, c);
					for (int f = 0; f < 2; f++)
					begin
						#1 b0 = cnt[2 * ch + inv];
						b1 = cnt[2 * ch + 1 - inv];
						repeat (4) prt.step(ch, f == 0);
						repeat (4) @(posedge ref_clk);
						n = m == 0 ? 1 : m == 1 ? 2 : 4;
						up = m == 3 ? 1 : f == 0 ? n : 0;
						dn = m == 3 ? 1 : f == 0 ? 0 : n;
						#1 chk(cnt[2 * ch + inv] - b0, up);
						chk(cnt[2 * ch + 1 - inv] - b1, dn);
					end
				end
	endtask
	task automatic t_filter();
		for (int ch = 0; ch < 2; ch++)
			for (int f = 0; f < 2; f++)
			begin
				c = '0;
				c.encoder_count_mode = CM_X4;
				c.pulser_count_mode = CM_X4;
				c.encoder_noise_filter_on = ch == 0 && f == 1;
				c.pulser_noise_filter_on = ch == 1 && f == 1;
				wr(REG_CFG, c);
				for (int w = 1; w < 4; w++)
				begin
					#1 b0 = cnt[2 * ch];
					b1 = cnt[2 * ch + 1];
					prt.glitch(ch, w);
					n = f == 0 || w >= FILT_MIN_CYCLES ? 1 : 0;
					#1 chk(cnt[2 * ch] - b0, n);
					chk(cnt[2 * ch + 1] - b1, n);
				end
			end
	endtask
	task automatic t_index();
		for (int s = 0; s < 2; s++)
		begin
			c = '0;
			c.index_edge_select = s[0];
			wr(REG_CFG, c);
			#1 b0 = cnt[4];
			prt.idx(1'b1);
			#1 chk(cnt[4] - b0, s);
			b0 = cnt[4];
			prt.idx(1'b0);
			#1 chk(cnt[4] - b0, 1 - s);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Whole run is about a thousand cycles; this leaves wide margin
	initial
	begin
		#400_000;
		err_count++;
		give_verdict();
	end

	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_regs();
		t_ports();
		t_oneshot();
		t_decode();
		t_filter();
		t_index();
		give_verdict();
	end
endmodule
`default_nettype wire
